// >>> design/disk_serial_datapath_checkword.v
/*
 * Disk data path: shift register, word buffer, MFM encoder, checkword.
 * Assumes a 50 MHz clock and asynchronous drive pulses on pins.
 */
`include "disk_datapath_regs.vh"
`default_nettype none
module disk_serial_datapath_checkword #(
    parameter DEPTH = 4,
    parameter STAGES = 36,
    parameter ACTIVE = 32
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_arst_n,
    // Register port.
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // System side word port of the buffer.
    input wire [15:0] i_sys_word,
    input wire i_sys_valid,
    output wire o_sys_ready,
    output reg [15:0] o_sys_word,
    output wire o_sys_valid,
    input wire i_sys_ready,
    // Drive side.
    input wire i_read_data_pulse,
    input wire i_read_clock_pulse,
    output reg o_encoded_write_stream,
    output reg o_write_gate,
    output reg o_internal_timing_clock,
    output reg o_write_phase_clock,
    output reg o_half_rate_clock
);
    // ****************************************
    // Timing constants.
    // ****************************************
    localparam STAGE_CYC = (`STAGE_NS + `CLK_NS - 1) / `CLK_NS;
    localparam STEP_CYC = (`STEP_NS + `CLK_NS - 1) / `CLK_NS;
    localparam [4:0] PRE_LEN = `PREAMBLE_BITS;
    // ****************************************
    // Registers.
    // ****************************************
    reg [15:0] ctrl_r;
    reg [31:0] div_r;
    reg [31:0] mul_r;
    reg [7:0] wbyte_r;
    reg wfull_r;
    reg [7:0] rbyte_r;
    reg rbyte_v_r;
    reg [7:0] cmpref_r;
    reg cmp_miss_r;
    reg [STAGES-1:0] crc_r;
    reg [7:0] sh_r;
    reg [3:0] bitcnt_r;
    reg wcatch_r;
    reg [1:0] cell_r;
    reg [4:0] pre_r;
    reg [1:0] osc_r;
    reg [2:0] step_r;
    reg [2:0] rdd_s_r;
    reg [2:0] rdc_s_r;
    reg rcatch_r;
    reg [15:0] stg_r [0:DEPTH-1];
    reg [DEPTH-1:0] sv_r;
    reg [1:0] rip_r;
    reg half_r;
    reg [7:0] hbyte_r;
    integer k;
    integer n;
    wire wr_mode = ctrl_r[`CTRL_WRITE];
    wire rd_mode = ctrl_r[`CTRL_READ];
    wire [3:0] blen = ctrl_r[`CTRL_BYTE8] ? 4'h8 : 4'h6;
    wire step = ctrl_r[`CTRL_STEP];
    // ****************************************
    // Clock generation: the fast source is quartered into two pulses and a square wave.
    // ****************************************
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            osc_r <= 2'h0;
            o_internal_timing_clock <= 1'b0;
            o_write_phase_clock <= 1'b0;
            o_half_rate_clock <= 1'b0;
        end else begin
            osc_r <= osc_r + 2'h1;
            o_internal_timing_clock <= (osc_r == 2'h0);
            o_write_phase_clock <= (osc_r == 2'h2);
            o_half_rate_clock <= osc_r[1];
        end
    end
    // Step one-shot fired by a control write.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_r <= 3'h0;
        end else if (step && i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_STEPFIRE]) begin
            step_r <= STEP_CYC[2:0];
        end else if (step_r != 3'h0) begin
            step_r <= step_r - 3'h1;
        end
    end
    // Read pins pass two flops; the edge is taken after the second.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdd_s_r <= 3'h0;
            rdc_s_r <= 3'h0;
        end else begin
            rdd_s_r <= {rdd_s_r[1:0], i_read_data_pulse};
            rdc_s_r <= {rdc_s_r[1:0], i_read_clock_pulse};
        end
    end
    wire rd_data_edge = rdd_s_r[1] & ~rdd_s_r[2];
    wire rd_clk_edge = rdc_s_r[1] & ~rdc_s_r[2];
    // Shift tick: step pulse, write phase clock or read clock.
    wire step_tick = (step_r == 3'h1);
    wire shift_tick = step ? step_tick :
        (wr_mode ? (osc_r == 2'h3) : (rd_mode & rd_clk_edge));
    // ****************************************
    // Checkword generator.
    // ****************************************
    wire shiftout = ctrl_r[`CTRL_SHIFTOUT];
    wire last = crc_r[ACTIVE-1];
    reg in_bit;
    reg [STAGES-1:0] crc_nxt;
    always @* begin
        in_bit = wr_mode ? sh_r[blen-1] : rcatch_r;
        crc_nxt = crc_r;
        crc_nxt[0] = shiftout ? 1'b0 : (wr_mode ? (in_bit ^ last) : 1'b0);
        if (rd_mode && !shiftout) begin
            // Stage zero sees a phantom previous stage of zero.
            case ({mul_r[0], div_r[0]})
                2'b11: crc_nxt[0] = in_bit ^ last;
                2'b10: crc_nxt[0] = in_bit;
                2'b01: crc_nxt[0] = last;
                default: crc_nxt[0] = 1'b0;
            endcase
        end
        for (k = 1; k < ACTIVE; k = k + 1) begin
            if (shiftout) begin
                crc_nxt[k] = crc_r[k-1];
            end else if (wr_mode) begin
                crc_nxt[k] = crc_r[k-1] ^ (div_r[k] & (in_bit ^ last));
            end else begin
                case ({mul_r[k], div_r[k]})
                    2'b11: crc_nxt[k] = crc_r[k-1] ^ in_bit ^ last;
                    2'b10: crc_nxt[k] = crc_r[k-1] ^ in_bit;
                    2'b01: crc_nxt[k] = crc_r[k-1] ^ last;
                    default: crc_nxt[k] = crc_r[k-1];
                endcase
            end
        end
        for (k = ACTIVE; k < STAGES; k = k + 1) begin
            crc_nxt[k] = 1'b0;
        end
    end
    // ****************************************
    // Shift register, bit counter, MFM encoder, read assembly.
    // ****************************************
    wire [15:0] buf_head = stg_r[DEPTH-1];
    wire head_v = sv_r[DEPTH-1];
    wire src_buf = ctrl_r[`CTRL_SRC_BUF];
    wire have_byte = src_buf ? head_v : wfull_r;
    wire [7:0] next_byte = src_buf ? (half_r ? buf_head[7:0] : buf_head[15:8]) : wbyte_r;
    wire preamble = (pre_r != 5'h0);
    wire wr_load = wr_mode && shift_tick && bitcnt_r == 4'h0 && !preamble && !shiftout;
    wire rd_done = rd_mode && shift_tick && bitcnt_r == blen - 4'h1;
    wire dst_buf = ctrl_r[`CTRL_DST_BUF];
    wire rd_to_buf = rd_done && dst_buf && !ctrl_r[`CTRL_CMP];
    wire [7:0] rd_byte = {sh_r[6:0], rcatch_r};
    wire [7:0] rd_mask = ctrl_r[`CTRL_BYTE8] ? 8'hff : 8'h3f;
    wire wr_pop = wr_load && src_buf && have_byte && half_r;
    wire tx_bit = shiftout ? last : (preamble ? 1'b0 : sh_r[blen-1]);
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sh_r <= 8'h00;
            bitcnt_r <= 4'h0;
            wcatch_r <= 1'b0;
            cell_r <= 2'h0;
            pre_r <= 5'h0;
            rcatch_r <= 1'b0;
            crc_r <= {STAGES{1'b0}};
            rbyte_r <= 8'h00;
            rbyte_v_r <= 1'b0;
            cmp_miss_r <= 1'b0;
            wfull_r <= 1'b0;
            o_encoded_write_stream <= 1'b0;
            o_write_gate <= 1'b0;
        end else begin
            cell_r <= cell_r + 2'h1;
            o_write_gate <= wr_mode;
            if (rd_data_edge) begin
                rcatch_r <= 1'b1;
            end else if (shift_tick && rd_mode) begin
                rcatch_r <= 1'b0;
            end
            if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_CLEAR]) begin
                crc_r <= {STAGES{1'b0}};
            end else if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_PRESET]) begin
                crc_r <= {{(STAGES-ACTIVE){1'b0}}, {ACTIVE{1'b1}}};
            end else if (shift_tick && (shiftout || (rd_mode && !ctrl_r[`CTRL_CMP]) ||
                         (wr_mode && bitcnt_r != 4'h0))) begin
                crc_r <= crc_nxt;
            end
            if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_PREAMBLE]) begin
                pre_r <= PRE_LEN;
            end else if (wr_mode && shift_tick && preamble) begin
                pre_r <= pre_r - 5'h1;
            end
            if (wr_load && have_byte) begin
                sh_r <= next_byte;
                bitcnt_r <= blen - 4'h1;
                if (!src_buf) begin
                    wfull_r <= 1'b0;
                end
            end else if (wr_mode && shift_tick && bitcnt_r != 4'h0) begin
                sh_r <= {sh_r[6:0], 1'b0};
                bitcnt_r <= bitcnt_r - 4'h1;
            end else if (rd_mode && shift_tick) begin
                sh_r <= {sh_r[6:0], rcatch_r};
                bitcnt_r <= rd_done ? 4'h0 : bitcnt_r + 4'h1;
            end
            if (i_wr && i_addr == `REG_WDATA) begin
                wfull_r <= 1'b1;
            end
            if (shift_tick && wr_mode) begin
                wcatch_r <= tx_bit;
            end
            // MFM: one pulses mid-cell, zero at cell start unless after one.
            if (wr_mode) begin
                if (cell_r == 2'h0) begin
                    o_encoded_write_stream <= ~tx_bit & ~wcatch_r;
                end else if (cell_r == 2'h2) begin
                    o_encoded_write_stream <= tx_bit;
                end else if (cell_r == 2'h3) begin
                    o_encoded_write_stream <= 1'b0;
                end
            end else begin
                o_encoded_write_stream <= 1'b0;
            end
            // Clear first, so that a miss in the same cycle wins.
            if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_CLEAR]) begin
                cmp_miss_r <= 1'b0;
            end
            if (rd_done) begin
                if (ctrl_r[`CTRL_CMP]) begin
                    cmp_miss_r <= cmp_miss_r | ((rd_byte & rd_mask) != (cmpref_r & rd_mask));
                end else if (!dst_buf) begin
                    rbyte_r <= rd_byte & rd_mask;
                    rbyte_v_r <= 1'b1;
                end
            end else if (i_rd && i_addr == `REG_RDATA) begin
                rbyte_v_r <= 1'b0;
            end
        end
    end
    // ****************************************
    // Four-stage word buffer with ripple timing.
    // ****************************************
    wire in_word_v = rd_mode ? (rd_to_buf && half_r) : i_sys_valid;
    wire [15:0] in_word = rd_mode ? {hbyte_r, rd_byte & rd_mask} : i_sys_word;
    assign o_sys_ready = ~rd_mode & ~sv_r[0];
    assign o_sys_valid = rd_mode & head_v;
    wire head_pop = rd_mode ? (head_v & i_sys_ready) : wr_pop;
    wire rip_go = (rip_r == STAGE_CYC[1:0] - 2'h1);
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sv_r <= {DEPTH{1'b0}};
            rip_r <= 2'h0;
            half_r <= 1'b0;
            hbyte_r <= 8'h00;
            o_sys_word <= 16'h0000;
        end else begin
            rip_r <= rip_go ? 2'h0 : rip_r + 2'h1;
            // The output copy is loaded with the word moving into the head.
            if (rip_go && sv_r[DEPTH-2] && (!head_v || head_pop)) begin
                o_sys_word <= stg_r[DEPTH-2];
            end
            if (rd_to_buf && !half_r) begin
                hbyte_r <= rd_byte & rd_mask;
            end
            if ((rd_to_buf) || (wr_load && src_buf && have_byte)) begin
                half_r <= ~half_r;
            end
            // Ripple one stage forward every 60 ns (three cycles) where the next is free.
            for (n = DEPTH - 1; n > 0; n = n - 1) begin
                if (rip_go && sv_r[n-1] && (!sv_r[n] || (n == DEPTH - 1 && head_pop))) begin
                    stg_r[n] <= stg_r[n-1];
                    sv_r[n] <= 1'b1;
                    sv_r[n-1] <= 1'b0;
                end else if (n == DEPTH - 1 && head_pop) begin
                    sv_r[n] <= 1'b0;
                end
            end
            if (in_word_v && !sv_r[0]) begin
                stg_r[0] <= in_word;
                sv_r[0] <= 1'b1;
            end else if (i_wr && i_addr == `REG_BUFIN && !sv_r[0]) begin
                stg_r[0] <= i_wdata[15:0];
                sv_r[0] <= 1'b1;
            end
        end
    end
    // ****************************************
    // Register file writes.
    // ****************************************
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r <= 16'h0000;
            div_r <= `DIVPOLY_RST;
            mul_r <= `MULPOLY_RST;
            wbyte_r <= 8'h00;
            cmpref_r <= 8'h00;
        end else if (i_wr) begin
            case (i_addr)
                `REG_CTRL: ctrl_r <= i_wdata[15:0] & 16'h0d9f;
                `REG_DIVPOLY: div_r <= i_wdata;
                `REG_MULPOLY: mul_r <= i_wdata;
                `REG_WDATA: wbyte_r <= i_wdata[7:0];
                `REG_CMPREF: cmpref_r <= i_wdata[7:0];
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end
    // Read data stand one cycle after the strobe.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `REG_CTRL: o_rdata <= {16'h0000, ctrl_r};
                `REG_DIVPOLY: o_rdata <= div_r;
                `REG_MULPOLY: o_rdata <= mul_r;
                `REG_RDATA: o_rdata <= {24'h000000, rbyte_r};
                `REG_STATUS: o_rdata <= {26'h0000000, ~sv_r[DEPTH-1], sv_r[0], cmp_miss_r,
                    ~wfull_r, rbyte_v_r, |crc_r[ACTIVE-1:0]};
                `REG_RESIDUE: o_rdata <= crc_r[ACTIVE-1:0];
                `REG_BUFOUT: o_rdata <= {15'h0000, head_v, buf_head};
                `REG_CMPREF: o_rdata <= {24'h000000, cmpref_r};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// >>> design/disk_datapath_regs.vh
/*
 * Constants of the disk data path: offsets, fields, resets and timing.
 * Assumes inclusion by bare name.
 */
`ifndef DISK_DATAPATH_REGS_VH
`define DISK_DATAPATH_REGS_VH

// ****************************************
// Register offsets (word index on the plain port).
// ****************************************
`define REG_CTRL 4'h0
`define REG_DIVPOLY 4'h1
`define REG_MULPOLY 4'h2
`define REG_WDATA 4'h3
`define REG_RDATA 4'h4
`define REG_STATUS 4'h5
`define REG_RESIDUE 4'h6
`define REG_BUFOUT 4'h7
`define REG_CMPREF 4'h8
`define REG_BUFIN 4'h9

// ****************************************
// Control register fields.
// ****************************************
`define CTRL_WRITE 0
`define CTRL_READ 1
`define CTRL_BYTE8 2
`define CTRL_CMP 3
`define CTRL_SRC_BUF 4
`define CTRL_CLEAR 5
`define CTRL_PRESET 6
`define CTRL_SHIFTOUT 7
`define CTRL_STEP 8
`define CTRL_STEPFIRE 9
`define CTRL_PREAMBLE 10
`define CTRL_DST_BUF 11

// ****************************************
// Status register fields.
// ****************************************
`define ST_RESIDUE_NZ 0
`define ST_RBYTE 1
`define ST_WEMPTY 2
`define ST_CMP_MISS 3
`define ST_BUF_FULL 4
`define ST_BUF_EMPTY 5

// ****************************************
// Reset values and timing.
// ****************************************
`define DIVPOLY_RST 32'h00a00805
`define MULPOLY_RST 32'h00000000
`define CLK_NS 20
`define STAGE_NS 50
`define STEP_NS 100
`define NATURAL_LEN 42987
`define PREAMBLE_BITS 16

`endif

// >>> dv/disk_datapath_properties.sv
/*
 * Checker of the data path ports.
 * Assumes binding onto the data path, one clock domain.
 */
`default_nettype none
// ****************************************
// Port relations.
// ****************************************
module disk_datapath_properties (
    // Clock, reset and register port.
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Buffer head, write gate and clocks.
    input wire logic [15:0] o_sys_word,
    input wire logic o_sys_valid,
    input wire logic i_sys_ready,
    input wire logic o_write_gate,
    input wire logic o_internal_timing_clock,
    input wire logic o_write_phase_clock,
    input wire logic o_half_rate_clock
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // Control write strobe.
    wire ctrl_wr = i_wr && (i_addr == 4'h0);
    a_divpoly_readback: assert property (
        i_wr && i_addr == 4'h1 ##2 i_rd && i_addr == 4'h1 |=> o_rdata == $past(i_wdata, 3))
        else $error("divide readback");
    a_mulpoly_readback: assert property (
        i_wr && i_addr == 4'h2 ##2 i_rd && i_addr == 4'h2 |=> o_rdata == $past(i_wdata, 3))
        else $error("multiply readback");
    a_unmapped_zero: assert property (
        i_rd && i_addr > 4'h9 |=> o_rdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_quiet: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0) else $error("stray read data");
    a_half_rate_wave: assert property (
        $rose(o_half_rate_clock) |=> o_half_rate_clock ##1 !o_half_rate_clock [*2]
        ##1 o_half_rate_clock) else $error("half rate period");
    a_timing_pulse: assert property (
        o_internal_timing_clock |=> !o_internal_timing_clock [*3] ##1 o_internal_timing_clock)
        else $error("timing spacing");
    a_phase_offset: assert property (
        o_internal_timing_clock |-> ##2 o_write_phase_clock)
        else $error("phase offset");
    a_head_held: assert property (
        o_sys_valid && !i_sys_ready |=> o_sys_valid && $stable(o_sys_word))
        else $error("head moved");
    a_gate_cause: assert property (
        $changed(o_write_gate) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("gate moved alone");
endmodule
bind disk_serial_datapath_checkword disk_datapath_properties u_props (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sys_word(o_sys_word),
    .o_sys_valid(o_sys_valid), .i_sys_ready(i_sys_ready), .o_write_gate(o_write_gate),
    .o_internal_timing_clock(o_internal_timing_clock),
    .o_write_phase_clock(o_write_phase_clock), .o_half_rate_clock(o_half_rate_clock)
);
`default_nettype wire

// >>> dv/disk_drive_model.sv
/*
 * Drive model: sends read data and clock pulses, sorts write pulse gaps.
 * Assumes a bench that calls send_bit.
 */
`default_nettype none
// ****************************************
// Drive.
// ****************************************
module disk_drive_model (
    // Clock and write side.
    input wire logic i_clk,
    input wire logic i_write_gate,
    input wire logic i_stream,
    // Read side pulses.
    output logic o_read_data_pulse,
    output logic o_read_clock_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    int cell_ns = 200;
    int n_pulse = 0;
    int n_short = 0;
    int n_bad = 0;
    int gap = 0;
    logic prev = 1'b0;
    initial begin
        o_read_data_pulse = 1'b0;
        o_read_clock_pulse = 1'b0;
    end
    // Data pulse for a one, clock pulse inside it.
    task automatic send_bit(input logic b);
        o_read_data_pulse = b;
        #40 o_read_clock_pulse = 1'b1;
        #60 o_read_data_pulse = 1'b0;
        o_read_clock_pulse = 1'b0;
        #(cell_ns - 100);
    endtask
    // Legal MFM gaps: 4, 6 or 8 cycles.
    always @(posedge i_clk) begin
        prev <= i_stream;
        gap <= gap + 1;
        if (!i_write_gate) begin
            n_pulse <= 0;
            n_short <= 0;
        end else if (i_stream && !prev) begin
            if (n_pulse > 0 && gap == 4) n_short <= n_short + 1;
            else if (n_pulse > 0 && gap != 6 && gap != 8) n_bad <= n_bad + 1;
            gap <= 1;
            n_pulse <= n_pulse + 1;
        end
    end
endmodule
`default_nettype wire

// >>> dv/test_disk_serial_datapath_checkword.sv
/*
 * Bench of the disk data path with random bytes and corner cases.
 * Assumes the data path, its header and the drive model.
 */
`include "disk_datapath_regs.vh"
`default_nettype none
// ****************************************
// Bench.
// ****************************************
module test_disk_serial_datapath_checkword;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] i_sys_word = 16'h0;
    logic i_sys_valid = 1'b0;
    logic i_sys_ready = 1'b0;
    wire [31:0] o_rdata;
    wire [15:0] o_sys_word;
    wire o_sys_ready, o_sys_valid, o_stream, o_gate, data_p, clock_p, itc;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int t, acc;
    logic rdy;
    logic [31:0] v, s;
    logic [7:0] b0, b1;
    localparam logic [31:0] MULS [4] = '{32'h3dc401ee, 32'he3600713, 32'h61e0230f, 32'h00a00805};
    disk_serial_datapath_checkword u_dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sys_word(i_sys_word),
        .i_sys_valid(i_sys_valid), .o_sys_ready(o_sys_ready), .o_sys_word(o_sys_word),
        .o_sys_valid(o_sys_valid), .i_sys_ready(i_sys_ready), .i_read_data_pulse(data_p),
        .i_read_clock_pulse(clock_p), .o_encoded_write_stream(o_stream),
        .o_write_gate(o_gate), .o_internal_timing_clock(itc), .o_write_phase_clock(),
        .o_half_rate_clock()
    );
    disk_drive_model u_drive (
        .i_clk(i_clk), .i_write_gate(o_gate), .i_stream(o_stream),
        .o_read_data_pulse(data_p), .o_read_clock_pulse(clock_p)
    );
    // Clock and watchdog.
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            end_of_test();
        end
    end
    function automatic logic [31:0] bt(input int n);
        return 32'h1 << n;
    endfunction
    // One generator step; each stage term follows its two polynomial bits.
    function automatic logic [31:0] crc(input logic [31:0] s, input logic b, input logic [31:0] m);
        logic [31:0] d;
        logic fb;
        d = `DIVPOLY_RST;
        fb = b ^ s[31];
        return {s[30:0], 1'b0} ^ (d & m & {32{fb}}) ^ (~d & m & {32{b}}) ^ (d & ~m & {32{s[31]}});
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Sends the low n bits, highest first, at a random cell time.
    task automatic send(input logic [7:0] b, input int n);
        u_drive.cell_ns = 160 + $urandom_range(240);
        for (int i = n - 1; i >= 0; i--) u_drive.send_bit(b[i]);
        repeat (10) @(posedge i_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(42));
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(`REG_DIVPOLY, v);
        chk("divide reset", v, `DIVPOLY_RST);
        rd(`REG_MULPOLY, v);
        chk("multiply reset", v, `MULPOLY_RST);
        rd(4'hf, v);
        chk("unmapped read", v, 32'h0);
        wr(`REG_DIVPOLY, `DIVPOLY_RST);
        rd(`REG_DIVPOLY, v);
        wr(`REG_MULPOLY, MULS[0]);
        rd(`REG_MULPOLY, v);
        $display("test registers done");
        // Eight and six bit bytes from the drive.
        for (int k = 0; k < 4; k++) begin
            b0 = 8'($urandom);
            wr(`REG_CTRL, bt(`CTRL_READ) | (k[0] ? 32'h0 : bt(`CTRL_BYTE8)));
            send(b0, k[0] ? 6 : 8);
            rd(`REG_STATUS, v);
            chk("byte ready", 32'(v[`ST_RBYTE]), 32'h1);
            rd(`REG_RDATA, v);
            chk("read byte", v, k[0] ? {26'h0, b0[5:0]} : {24'h0, b0});
            rd(`REG_STATUS, v);
            chk("byte ready cleared", 32'(v[`ST_RBYTE]), 32'h0);
        end
        $display("test byte assembly done");
        // Each multiply polynomial; the natural one also reads its checkword.
        for (int j = 0; j < 4; j++) begin
            wr(`REG_MULPOLY, MULS[j]);
            wr(`REG_CTRL, bt(`CTRL_READ) | bt(`CTRL_BYTE8) | bt(`CTRL_CLEAR));
            s = 32'h0;
            for (int k = 0; k < 3; k++) begin
                b0 = 8'($urandom);
                send(b0, 8);
                for (int i = 7; i >= 0; i--) s = crc(s, b0[i], MULS[j]);
            end
            if (j == 3) begin
                v = s;
                for (int k = 3; k >= 0; k--) send(v[k * 8 +: 8], 8);
                for (int i = 31; i >= 0; i--) s = crc(s, v[i], MULS[j]);
            end
            rd(`REG_RESIDUE, v);
            chk("residue", v, s);
            rd(`REG_STATUS, v);
            chk("residue flag", 32'(v[`ST_RESIDUE_NZ]), 32'(s != 32'h0));
        end
        // Zero multiply: cleared stays clean, preset forces an error.
        wr(`REG_MULPOLY, 32'h0);
        wr(`REG_CTRL, bt(`CTRL_READ) | bt(`CTRL_BYTE8) | bt(`CTRL_CLEAR));
        send(8'($urandom), 8);
        rd(`REG_RESIDUE, v);
        chk("blocked residue", v, 32'h0);
        wr(`REG_CTRL, bt(`CTRL_READ) | bt(`CTRL_BYTE8) | bt(`CTRL_PRESET));
        send(8'($urandom), 8);
        rd(`REG_STATUS, v);
        chk("forced error", 32'(v[`ST_RESIDUE_NZ]), 32'h1);
        $display("test checkword done");
        // Compare: a match and a miss, neither stored.
        b0 = 8'($urandom);
        wr(`REG_CMPREF, {24'h0, b0});
        wr(`REG_CTRL, bt(`CTRL_READ) | bt(`CTRL_BYTE8) | bt(`CTRL_CMP) | bt(`CTRL_CLEAR));
        rd(`REG_RDATA, v);
        send(b0, 8);
        rd(`REG_STATUS, v);
        chk("compare match", 32'({v[`ST_CMP_MISS], v[`ST_RBYTE]}), 32'h0);
        send(~b0, 8);
        rd(`REG_STATUS, v);
        chk("compare miss", 32'({v[`ST_CMP_MISS], v[`ST_RBYTE]}), 32'h2);
        $display("test compare done");
        // Two bytes make one word at the buffer head.
        wr(`REG_CTRL, bt(`CTRL_READ) | bt(`CTRL_BYTE8) | bt(`CTRL_DST_BUF));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        send(b0, 8);
        send(b1, 8);
        for (t = 0; t < 100 && o_sys_valid !== 1'b1; t++) @(posedge i_clk) #1;
        #1 chk("word out", 32'(o_sys_word), 32'({b0, b1}));
        rd(`REG_BUFOUT, v);
        chk("head as status", v, {15'h0, 1'b1, b0, b1});
        @(posedge i_clk) i_sys_ready <= 1'b1;
        @(posedge i_clk) i_sys_ready <= 1'b0;
        // System words fill all four stages.
        wr(`REG_CTRL, 32'h0);
        acc = 0;
        rdy = 1'b0;
        for (int k = 0; k < 40; k++) begin
            @(posedge i_clk);
            if (rdy) acc++;
            i_sys_valid <= 1'b1;
            i_sys_word <= 16'($urandom);
            #1 rdy = o_sys_ready;
        end
        @(posedge i_clk) i_sys_valid <= 1'b0;
        chk("words taken", acc, 32'h4);
        rd(`REG_STATUS, v);
        chk("input stage full", 32'(v[`ST_BUF_FULL]), 32'h1);
        $display("test buffer done");
        // Write: zero preamble, bytes with corner patterns, then the residue.
        wr(`REG_CTRL, bt(`CTRL_WRITE) | bt(`CTRL_BYTE8) | bt(`CTRL_PREAMBLE));
        repeat (60) @(posedge i_clk);
        chk("preamble gaps", u_drive.n_pulse - 1 - u_drive.n_short, 32'h0);
        chk("preamble pulses", 32'(u_drive.n_pulse > 10), 32'h1);
        for (int k = 0; k < 7; k++) begin
            for (int w = 0; w < 100; w++) begin
                rd(`REG_STATUS, v);
                if (v[`ST_WEMPTY] === 1'b1) break;
            end
            if (k < 6) wr(`REG_WDATA, k < 2 ? (k ? 32'h55 : 32'hff) : $urandom);
        end
        // Let the last byte out, then switch on a cell boundary.
        repeat (32) @(posedge i_clk);
        do @(posedge i_clk) #1; while (itc !== 1'b1);
        @(posedge i_clk);
        wr(`REG_CTRL, bt(`CTRL_WRITE) | bt(`CTRL_BYTE8) | bt(`CTRL_SHIFTOUT));
        repeat (136) @(posedge i_clk);
        chk("bad gaps", u_drive.n_bad, 32'h0);
        chk("write pulses", 32'(u_drive.n_pulse > 40), 32'h1);
        wr(`REG_CTRL, 32'h0);
        $display("test write done");
        end_of_test();
    end
endmodule
`default_nettype wire
